//--- pkg/daq_pkg.sv
// shared constants and types for the multifunction acquisition core
//
// Behaviour
// - sixteen single-ended or eight differential inputs
// - one channel at a time reaches converter
// - grounding mode chosen per scan entry
// - four ranges, set per scan entry
// - scan list converts channels in any order
// - each result is sixteen bits wide
// - results queue in acquisition fifo, finite or endless
// - two sixteen-bit output converters
// - outputs: static write or timed waveform
// - generation fifo streams or replays stored waveform
// - output sample clock pops and applies sample
// - direction set per digital line
// - sixteen lines form one port, indices 0..15
// - line is plain or programmable function line
// - change detection raises event on line change
// - four 32-bit counters routable to any line
// - count, frequency, encoder, frequency and pulse generation
// - each subsystem has own timing engine
// - start trigger and sample clock routable from lines
// - static lines plus clocked digital waveform fifos
package daq_pkg;
   localparam int NLINE = 16;
   localparam int NCTR = 4;
   localparam int NENG = 4;
   // engine indices
   localparam int ENG_AI = 0;
   localparam int ENG_AO = 1;
   localparam int ENG_DI = 2;
   localparam int ENG_DO = 3;
   // register word addresses
   localparam logic [7:0] R_START = 8'h00;
   localparam logic [7:0] R_CFG = 8'h01;
   localparam logic [7:0] R_STATUS = 8'h02;
   localparam logic [7:0] R_SCAN_LEN = 8'h03;
   localparam logic [7:0] R_AI_COUNT = 8'h04;
   localparam logic [7:0] R_ACQ_DATA = 8'h05;
   localparam logic [7:0] R_GEN_DATA = 8'h06;
   localparam logic [7:0] R_AO_STATIC = 8'h07;
   localparam logic [7:0] R_DIO_DIR = 8'h08;
   localparam logic [7:0] R_DIO_OUT = 8'h09;
   localparam logic [7:0] R_DIO_FUNC = 8'h0A;
   localparam logic [7:0] R_CHG_RISE = 8'h0B;
   localparam logic [7:0] R_CHG_FALL = 8'h0C;
   localparam logic [7:0] R_DO_DATA = 8'h0D;
   localparam logic [7:0] R_DI_DATA = 8'h0E;
   localparam logic [5:0] R_TIMING = 6'h04;   // 0x10..0x13
   localparam logic [5:0] R_CTR_CFG = 6'h05;  // 0x14..0x17
   localparam logic [5:0] R_CTR_PER = 6'h06;  // 0x18..0x1B
   localparam logic [5:0] R_CTR_CNT = 6'h07;  // 0x1C..0x1F
   localparam logic [3:0] R_SCAN_ENT = 4'h2;  // 0x20..0x2F
   localparam logic [3:0] R_ROUTE = 4'h3;     // 0x30..0x3F
   // status flag positions
   localparam int F_OVF = 0;
   localparam int F_UNDR = 1;
   localparam int F_CHG = 2;
   // config bit positions
   localparam int C_REGEN = 0;
   localparam int C_WAVE0 = 1;
   localparam int C_WAVE1 = 2;
   localparam int C_FINITE = 3;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   typedef enum logic [1:0] {GND_DIFF = 2'b00, GND_RSE = 2'b01, GND_NRSE = 2'b10} gnd_t;
   typedef enum logic [2:0] {
      CM_COUNT = 3'b000, CM_FREQ = 3'b001, CM_ENC = 3'b010, CM_FGEN = 3'b011,
      CM_PULSE = 3'b100
   } ctr_mode_t;
   typedef enum logic {AI_IDLE = 1'b0, AI_CONV = 1'b1} ai_st_t;
endpackage

//--- design/daq_core.sv
// multifunction acquisition core: scan, fifos, outputs, digital lines, counters
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// simple fifo; depth must be a power of two
module daq_fifo #(
   parameter int W = 16,
   parameter int D = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // write side
   input wire logic push_i,
   input wire logic [W-1:0] wd_i,
   output logic full_o,
   // read side
   input wire logic pop_i,
   output logic [W-1:0] rd_o,
   output logic empty_o
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] n_q;
   wire wr = push_i && (!full_o || pop_i);
   wire rd = pop_i && !empty_o;
   assign full_o = (n_q == (AW+1)'(D));
   assign empty_o = (n_q == '0);
   assign rd_o = mem[rp_q];
   // storage write
   always_ff @(posedge clk_i) begin
      if (ce_i && wr) begin
         mem[wp_q] <= wd_i;
      end
   end
   // pointers and fill level
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         wp_q <= '0;
         rp_q <= '0;
         n_q <= '0;
      end else if (ce_i) begin
         if (wr) wp_q <= wp_q + 1'b1;
         if (rd) rp_q <= rp_q + 1'b1;
         n_q <= n_q + (AW+1)'(wr) - (AW+1)'(rd);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module daq_core import daq_pkg::*; #(
   parameter int ACQ_DEPTH = 16,
   parameter int GEN_DEPTH = 16,
   parameter int DIO_DEPTH = 16
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [31:0] rdata_o,
   // converter front end
   input wire logic [15:0] adc_data_i,
   input wire logic adc_done_i,
   output logic conv_start_o,
   output logic [3:0] mux_sel_o,
   output logic [1:0] range_o,
   output logic [1:0] ground_o,
   // output converters
   output logic [15:0] dac0_o,
   output logic [15:0] dac1_o,
   // digital lines
   input wire logic [NLINE-1:0] dio_i,
   output logic [NLINE-1:0] dio_o,
   output logic [NLINE-1:0] dio_oe_o,
   output logic chg_event_o
);
   // registers
   logic [3:0] cfg_q;
   logic [2:0] flag_q;
   logic [3:0] slen_q;
   logic [31:0] ai_cnt_q;
   logic [NLINE-1:0] dir_q, dout_q, func_q, rmask_q, fmask_q;
   logic [7:0] scan_q [16];
   logic [2:0] route_q [NLINE];
   logic [31:0] tim_q [NENG];
   logic [11:0] ccfg_q [NCTR];
   logic [31:0] cper_q [NCTR];
   logic [31:0] rmux;
   // synchronisers and edges
   logic [NLINE-1:0] lin_m_q, lin_q, lin_p_q;
   logic [15:0] adc_m_q, adc_q;
   logic done_m_q, done_q, done_p_q;
   // engines, scan, outputs
   logic [NENG-1:0] arm_q, run_q, tick, trig, int_tc;
   logic [15:0] div_q [NENG];
   ai_st_t ai_st_q;
   logic [3:0] idx_q;
   logic [31:0] ctr_val [NCTR];
   logic [NCTR-1:0] ctr_out;
   logic [NLINE-1:0] route_val;

   ////////////////////////////////////////////////////////////////////////////
   // register write and read decode
   wire wr_start = we_i && addr_i == R_START;
   wire wr_gen = we_i && addr_i == R_GEN_DATA;
   wire wr_aos = we_i && addr_i == R_AO_STATIC;
   wire wr_dout = we_i && addr_i == R_DIO_OUT;
   wire wr_do = we_i && addr_i == R_DO_DATA;
   wire wr_stat = we_i && addr_i == R_STATUS;
   wire rd_acq = re_i && addr_i == R_ACQ_DATA;
   wire rd_di = re_i && addr_i == R_DI_DATA;
   wire [1:0] sub = addr_i[1:0];

   // edge detection on synchronised inputs
   wire [NLINE-1:0] line_rise = lin_q & ~lin_p_q;
   wire [NLINE-1:0] line_fall = ~lin_q & lin_p_q;
   wire done_rise = done_q && !done_p_q;
   wire chg_any = |((line_rise & rmask_q) | (line_fall & fmask_q));

   // scan entry in use
   wire [7:0] cur_ent = scan_q[idx_q];
   wire [1:0] cur_rng = cur_ent[5:4];
   wire [1:0] cur_gnd = cur_ent[7:6];
   // differential use reaches only eight pairs
   wire [3:0] cur_ch = (cur_gnd == GND_DIFF) ? {1'b0, cur_ent[2:0]} : cur_ent[3:0];
   wire ai_go = tick[ENG_AI] && ai_st_q == AI_IDLE;

   wire acq_push = done_rise && ai_st_q == AI_CONV;
   wire acq_full, acq_empty;
   wire [15:0] acq_head;
   wire ovf = acq_push && acq_full;
   wire ai_last = acq_push && cfg_q[C_FINITE] && ai_cnt_q <= 32'h0000_0001;

   // output sample clock pops generation fifo
   wire gen_full, gen_empty;
   wire [31:0] gen_head;
   wire gen_pop = tick[ENG_AO] && !gen_empty;
   wire [15:0] gen_lo = gen_head[15:0];
   wire undr = tick[ENG_AO] && gen_empty;
   wire regen_push = cfg_q[C_REGEN] && gen_pop;
   wire gen_push = regen_push || wr_gen;
   wire [31:0] gen_wd = regen_push ? gen_head : wdata_i;

   wire do_full, do_empty, di_full, di_empty;
   wire [15:0] do_head, di_head;
   wire do_pop = tick[ENG_DO] && !do_empty;

   wire [NENG-1:0] start_req = wr_start ? wdata_i[3:0] : 4'h0;
   wire [NENG-1:0] stop_req = (wr_start ? wdata_i[7:4] : 4'h0) |
      {2'b00, undr, ovf || ai_last};

   ////////////////////////////////////////////////////////////////////////////
   daq_fifo #(.W(16), .D(ACQ_DEPTH)) u_acq (
      .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
      .push_i(acq_push), .wd_i(adc_q), .full_o(acq_full),
      .pop_i(rd_acq), .rd_o(acq_head), .empty_o(acq_empty));
   daq_fifo #(.W(32), .D(GEN_DEPTH)) u_gen (
      .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
      .push_i(gen_push), .wd_i(gen_wd), .full_o(gen_full),
      .pop_i(gen_pop), .rd_o(gen_head), .empty_o(gen_empty));
   daq_fifo #(.W(16), .D(DIO_DEPTH)) u_do (
      .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
      .push_i(wr_do), .wd_i(wdata_i[15:0]), .full_o(do_full),
      .pop_i(do_pop), .rd_o(do_head), .empty_o(do_empty));
   daq_fifo #(.W(16), .D(DIO_DEPTH)) u_di (
      .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
      .push_i(tick[ENG_DI]), .wd_i(lin_q), .full_o(di_full),
      .pop_i(rd_di), .rd_o(di_head), .empty_o(di_empty));

   ////////////////////////////////////////////////////////////////////////////
   // one timing engine per subsystem
   for (genvar e = 0; e < NENG; e++) begin : g_eng
      wire [31:0] t = tim_q[e];
      assign int_tc[e] = div_q[e] == t[31:16];
      // sample clock from divider or a line
      assign tick[e] = run_q[e] && (t[4] ? int_tc[e] : line_rise[t[3:0]]);
      // start trigger: immediate or line edge
      assign trig[e] = t[9] || line_rise[t[8:5]];
   end

   // counter outputs and sample clocks onto lines
   for (genvar l = 0; l < NLINE; l++) begin : g_line
      wire [2:0] r = route_q[l];
      assign route_val[l] = r[2] ? tick[r[1:0]] : ctr_out[r[1:0]];
   end

   for (genvar c = 0; c < NCTR; c++) begin : g_ctr
      logic [31:0] cnt_q, tm_q, acc_q;
      logic out_q;
      wire [11:0] cf = ccfg_q[c];
      wire [31:0] per = cper_q[c];
      wire src_r = line_rise[cf[6:3]];
      wire aux = lin_q[cf[10:7]];
      wire tc = tm_q == per;
      wire tcp = tm_q[15:0] == per[15:0];
      assign ctr_val[c] = cnt_q;
      assign ctr_out[c] = out_q;
      always_ff @(posedge clk_i or posedge reset_i) begin
         if (reset_i) begin
            cnt_q <= '0;
            tm_q <= '0;
            acc_q <= '0;
            out_q <= 1'b0;
         end else if (ce_i) begin
            if (!cf[11]) begin
               cnt_q <= '0;
               tm_q <= '0;
               acc_q <= '0;
               out_q <= 1'b0;
            end else begin
               case (ctr_mode_t'(cf[2:0]))
                  CM_COUNT: if (src_r) cnt_q <= cnt_q + 1'b1;
                  CM_FREQ: begin
                     tm_q <= tc ? '0 : tm_q + 1'b1;
                     if (tc) begin
                        cnt_q <= acc_q;
                        acc_q <= {31'h0, src_r};
                     end else if (src_r) begin
                        acc_q <= acc_q + 1'b1;
                     end
                  end
                  CM_ENC: if (src_r) cnt_q <= aux ? cnt_q - 1'b1 : cnt_q + 1'b1;
                  CM_FGEN: begin
                     tm_q <= tc ? '0 : tm_q + 1'b1;
                     if (tc) out_q <= ~out_q;
                  end
                  CM_PULSE: begin
                     tm_q <= tcp ? '0 : tm_q + 1'b1;
                     out_q <= tm_q[15:0] < per[31:16];
                  end
                  default: cnt_q <= cnt_q;
               endcase
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers and edge history
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         lin_m_q <= '0;
         lin_q <= '0;
         lin_p_q <= '0;
         adc_m_q <= '0;
         adc_q <= '0;
         done_m_q <= 1'b0;
         done_q <= 1'b0;
         done_p_q <= 1'b0;
      end else if (ce_i) begin
         lin_m_q <= dio_i;
         lin_q <= lin_m_q;
         lin_p_q <= lin_q;
         adc_m_q <= adc_data_i;
         adc_q <= adc_m_q;
         done_m_q <= adc_done_i;
         done_q <= done_m_q;
         done_p_q <= done_q;
      end
   end

   // engine arm and run state, internal dividers
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         arm_q <= '0;
         run_q <= '0;
         for (int e = 0; e < NENG; e++) div_q[e] <= '0;
      end else if (ce_i) begin
         for (int e = 0; e < NENG; e++) begin
            if (stop_req[e]) begin
               arm_q[e] <= 1'b0;
               run_q[e] <= 1'b0;
            end else if (start_req[e]) begin
               arm_q[e] <= 1'b1;
            end else if (arm_q[e] && trig[e]) begin
               arm_q[e] <= 1'b0;
               run_q[e] <= 1'b1;
            end
            div_q[e] <= (!run_q[e] || int_tc[e]) ? '0 : div_q[e] + 1'b1;
         end
      end
   end

   // scan sequencer, one conversion at a time
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         ai_st_q <= AI_IDLE;
         idx_q <= '0;
         conv_start_o <= 1'b0;
         mux_sel_o <= '0;
         range_o <= '0;
         ground_o <= '0;
      end else if (ce_i) begin
         conv_start_o <= ai_go;
         if (start_req[ENG_AI]) idx_q <= '0;
         case (ai_st_q)
            AI_IDLE: if (ai_go) begin
               ai_st_q <= AI_CONV;
               mux_sel_o <= cur_ch;
               range_o <= cur_rng;
               ground_o <= cur_gnd;
            end
            AI_CONV: if (done_rise) begin
               ai_st_q <= AI_IDLE;
               idx_q <= (idx_q == slen_q) ? '0 : idx_q + 1'b1;
            end
            default: ai_st_q <= AI_IDLE;
         endcase
      end
   end

   // configuration registers
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cfg_q <= '0;
         slen_q <= '0;
         ai_cnt_q <= RST_WORD;
         {dir_q, func_q, rmask_q, fmask_q} <= '0;
         for (int i = 0; i < 16; i++) scan_q[i] <= '0;
         for (int i = 0; i < NLINE; i++) route_q[i] <= '0;
         for (int i = 0; i < NENG; i++) tim_q[i] <= RST_WORD;
         for (int i = 0; i < NCTR; i++) ccfg_q[i] <= '0;
         for (int i = 0; i < NCTR; i++) cper_q[i] <= RST_WORD;
      end else if (ce_i) begin
         if (we_i && addr_i == R_CFG) cfg_q <= wdata_i[3:0];
         if (we_i && addr_i == R_SCAN_LEN) slen_q <= wdata_i[3:0];
         if (we_i && addr_i == R_AI_COUNT) ai_cnt_q <= wdata_i;
         else if (acq_push && ai_cnt_q != 32'h0) ai_cnt_q <= ai_cnt_q - 1'b1;
         if (we_i && addr_i == R_DIO_DIR) dir_q <= wdata_i[15:0];
         if (we_i && addr_i == R_DIO_FUNC) func_q <= wdata_i[15:0];
         if (we_i && addr_i == R_CHG_RISE) rmask_q <= wdata_i[15:0];
         if (we_i && addr_i == R_CHG_FALL) fmask_q <= wdata_i[15:0];
         if (we_i && addr_i[7:4] == R_SCAN_ENT) scan_q[addr_i[3:0]] <= wdata_i[7:0];
         if (we_i && addr_i[7:4] == R_ROUTE) route_q[addr_i[3:0]] <= wdata_i[2:0];
         if (we_i && addr_i[7:2] == R_TIMING) tim_q[sub] <= wdata_i;
         if (we_i && addr_i[7:2] == R_CTR_CFG) ccfg_q[sub] <= wdata_i[11:0];
         if (we_i && addr_i[7:2] == R_CTR_PER) cper_q[sub] <= wdata_i;
      end
   end

   // outputs, flags, read data
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         flag_q <= '0;
         dac0_o <= '0;
         dac1_o <= '0;
         dout_q <= '0;
         dio_o <= '0;
         dio_oe_o <= '0;
         chg_event_o <= 1'b0;
         rdata_o <= RST_WORD;
      end else if (ce_i) begin
         // sticky flags, set wins over clear
         flag_q <= (flag_q & ~(wr_stat ? wdata_i[2:0] : 3'h0)) | {chg_any, undr, ovf};
         chg_event_o <= chg_any;
         // waveform or static update per channel
         if (gen_pop && cfg_q[C_WAVE0]) dac0_o <= gen_head[15:0];
         else if (wr_aos && !cfg_q[C_WAVE0]) dac0_o <= wdata_i[15:0];
         if (gen_pop && cfg_q[C_WAVE1]) dac1_o <= gen_head[31:16];
         else if (wr_aos && !cfg_q[C_WAVE1]) dac1_o <= wdata_i[31:16];
         if (do_pop) dout_q <= do_head;
         else if (wr_dout) dout_q <= wdata_i[15:0];
         dio_o <= (func_q & route_val) | (~func_q & dout_q);
         dio_oe_o <= dir_q;
         rdata_o <= re_i ? rmux : RST_WORD;
      end
   end

   // read selection
   always_comb begin
      if (addr_i == R_CFG) rmux = {28'h0, cfg_q};
      else if (addr_i == R_STATUS)
         rmux = {20'h0, run_q, do_full, di_empty, gen_full, acq_empty, 1'b0, flag_q};
      else if (addr_i == R_SCAN_LEN) rmux = {28'h0, slen_q};
      else if (addr_i == R_AI_COUNT) rmux = ai_cnt_q;
      else if (addr_i == R_ACQ_DATA) rmux = {16'h0, acq_head};
      else if (addr_i == R_AO_STATIC) rmux = {dac1_o, dac0_o};
      else if (addr_i == R_DIO_DIR) rmux = {16'h0, dir_q};
      // one port, bit n is line n
      else if (addr_i == R_DIO_OUT) rmux = {16'h0, lin_q};
      else if (addr_i == R_DIO_FUNC) rmux = {16'h0, func_q};
      else if (addr_i == R_CHG_RISE) rmux = {16'h0, rmask_q};
      else if (addr_i == R_CHG_FALL) rmux = {16'h0, fmask_q};
      else if (addr_i == R_DI_DATA) rmux = {16'h0, di_head};
      else if (addr_i[7:4] == R_SCAN_ENT) rmux = {24'h0, scan_q[addr_i[3:0]]};
      else if (addr_i[7:4] == R_ROUTE) rmux = {29'h0, route_q[addr_i[3:0]]};
      else if (addr_i[7:2] == R_TIMING) rmux = tim_q[sub];
      else if (addr_i[7:2] == R_CTR_CFG) rmux = {20'h0, ccfg_q[sub]};
      else if (addr_i[7:2] == R_CTR_PER) rmux = cper_q[sub];
      else if (addr_i[7:2] == R_CTR_CNT) rmux = ctr_val[sub];
      else rmux = RST_WORD;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   diff_mux_a: assert property (conv_start_o && ground_o == GND_DIFF |-> !mux_sel_o[3])
      else $error("differential scan selected upper channel");
   one_conv_a: assert property (ce_i && conv_start_o |=> !conv_start_o)
      else $error("conversion start longer than one cycle");
   scan_range_a: assert property (ce_i && ai_go |=> conv_start_o && range_o == $past(cur_rng))
      else $error("range does not follow scan entry");
   acq_ovf_a: assert property (ce_i && ovf |=> flag_q[F_OVF] && !run_q[ENG_AI])
      else $error("overflow not flagged or scan not halted");
   gen_undr_a: assert property (ce_i && undr |=> flag_q[F_UNDR] && !run_q[ENG_AO])
      else $error("underflow not flagged or output not halted");
   ao_apply_a: assert property (ce_i && gen_pop && cfg_q[C_WAVE0] |=> dac0_o == $past(gen_lo))
      else $error("output sample not applied");
   line_dir_a: assert property (ce_i |=> dio_oe_o == $past(dir_q))
      else $error("line enable differs from direction");
   chg_flag_a: assert property (ce_i && chg_any |=> flag_q[F_CHG] && chg_event_o)
      else $error("line change not reported");

   acq_cov_c: cover property (ce_i && acq_push && !acq_full);
   regen_cov_c: cover property (ce_i && regen_push);
   chg_cov_c: cover property (ce_i && chg_any);
   ovf_cov_c: cover property (ce_i && ovf);
endmodule

//--- dv/adc_model.sv
// converter front-end model that answers each conversion start
`timescale 1ns/1ps
module adc_model (
   // clock and request
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic [3:0] mux_i,
   input wire logic [1:0] rng_i,
   input wire logic [1:0] gnd_i,
   input wire logic [3:0] dly_i,
   // result
   output logic [15:0] data_o,
   output logic done_o
);
   // result encodes the selection so the bench sees what was converted
   initial begin
      data_o = 16'h0000;
      done_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (start_i) begin
            data_o <= ~data_o; // stale while converting
            repeat (dly_i + 1) @(posedge clk_i);
            data_o <= {mux_i, rng_i, gnd_i, 8'hA5};
            done_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            done_o <= 1'b0;
         end
      end
   end
endmodule

//--- dv/test_multifunction_daq_core.sv
// self-checking bench for the acquisition core
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
 $display("wrong value at %0t got %h expected %h", $time, a, e); end end
module test_multifunction_daq_core import daq_pkg::*;;
   logic clk_i = 0, reset_i = 1, ce_i = 1, we_i = 0, re_i = 0, adc_done_i;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0, rdata_o, v, w0, w1;
   logic [15:0] adc_data_i, dac0_o, dac1_o, dio_i = 16'h0, dio_o, dio_oe_o;
   logic [3:0] mux_sel_o, dly = 4'h0, c, l;
   logic [1:0] range_o, ground_o;
   logic conv_start_o, chg_event_o;
   logic [7:0] ent [5];
   int seed = 24678, bad_count = 0, check_count = 0, i, n;
   localparam logic [31:0] TMG = 32'h001D_0210; // internal, immediate, /30
   daq_core #(.ACQ_DEPTH(8), .GEN_DEPTH(4), .DIO_DEPTH(4)) dut_u (
      .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
      .adc_data_i(adc_data_i), .adc_done_i(adc_done_i), .conv_start_o(conv_start_o),
      .mux_sel_o(mux_sel_o), .range_o(range_o), .ground_o(ground_o),
      .dac0_o(dac0_o), .dac1_o(dac1_o), .dio_i(dio_i), .dio_o(dio_o),
      .dio_oe_o(dio_oe_o), .chg_event_o(chg_event_o));
   adc_model adc_u (.clk_i(clk_i), .start_i(conv_start_o), .mux_i(mux_sel_o),
      .rng_i(range_o), .gnd_i(ground_o), .dly_i(dly), .data_o(adc_data_i),
      .done_o(adc_done_i));
   ////////////////////////////////////////////////////////////////////////
   // clock, and a fresh converter delay per conversion
   initial forever #50 clk_i = ~clk_i;
   always @(posedge clk_i) if (conv_start_o) dly <= 4'($random(seed));
   // register bus cycles
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      we_i <= 1'b1;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      re_i <= 1'b1;
      @(posedge clk_i);
      re_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   // poll until an engine stops running
   task idle(input int b);
      rd(R_STATUS);
      for (int k = 0; k < 200 && v[8+b] !== 1'b0; k++) rd(R_STATUS);
   endtask
   // expected result word for a scan entry
   function logic [15:0] ai_exp(input logic [7:0] e);
      return {e[7:6] == GND_DIFF ? {1'b0, e[2:0]} : e[3:0], e[5:4], e[7:6], 8'hA5};
   endfunction
   task final_report;
      $display("comparisons %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      final_report;
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(R_STATUS);
      `CHK(v, 32'h0000_0050)
      rd(8'h0F);
      `CHK(v, 32'h0)
      for (i = 0; i < 4; i++) begin
         w0 = $random(seed);
         wr(R_DIO_DIR, {16'h0, w0[15:0]});
         wr(R_DIO_OUT, {16'h0, w0[31:16]});
         repeat (2) @(negedge clk_i);
         `CHK(dio_oe_o, w0[15:0])
         `CHK(dio_o & w0[15:0], w0[31:16] & w0[15:0])
      end
      wr(R_DIO_DIR, 32'h0);
      dio_i <= 16'($random(seed));
      repeat (3) @(posedge clk_i);
      rd(R_DIO_OUT);
      `CHK(v[15:0], dio_i)
      w0 = $random(seed);
      wr(R_AO_STATIC, w0);
      repeat (2) @(negedge clk_i);
      `CHK({dac1_o, dac0_o}, w0)
      // scan list: top then bottom channel, a differential entry with bit 3
      for (i = 0; i < 5; i++) begin
         w0 = $random(seed);
         ent[i] = {(i == 2) ? GND_DIFF : (w0[7] ? GND_RSE : GND_NRSE), w0[5:0]};
         wr(8'h20 + i[7:0], {24'h0, ent[i]});
      end
      ent[0][3:0] = 4'hF;
      ent[1][3:0] = 4'h0;
      ent[2][3] = 1'b1;
      for (i = 0; i < 3; i++) wr(8'h20 + i[7:0], {24'h0, ent[i]});
      wr(R_SCAN_LEN, 32'h4);
      wr(R_AI_COUNT, 32'h5);
      wr(R_CFG, 32'h8);
      wr(8'h10, TMG);
      wr(R_START, 32'h1);
      idle(ENG_AI);
      for (i = 0; i < 5; i++) begin
         rd(R_ACQ_DATA);
         `CHK(v[15:0], ai_exp(ent[i]))
      end
      rd(R_STATUS);
      `CHK(v[4], 1'b1)
      // endless scan into an 8-deep fifo must overflow and stop
      wr(R_CFG, 32'h0);
      wr(R_START, 32'h1);
      idle(ENG_AI);
      rd(R_STATUS);
      `CHK(v[F_OVF], 1'b1)
      wr(R_STATUS, 32'h1);
      rd(R_STATUS);
      `CHK(v[F_OVF], 1'b0)
      // streamed waveform runs dry, then a regenerated one does not
      w0 = $random(seed);
      w1 = $random(seed);
      wr(R_CFG, 32'h6);
      wr(R_GEN_DATA, w0);
      wr(R_GEN_DATA, w1);
      wr(8'h11, TMG);
      wr(R_START, 32'h2);
      idle(ENG_AO);
      `CHK({dac1_o, dac0_o}, w1)
      `CHK(v[F_UNDR], 1'b1)
      wr(R_STATUS, 32'h2);
      wr(R_CFG, 32'h7);
      wr(R_GEN_DATA, w0);
      wr(R_GEN_DATA, w1);
      wr(R_START, 32'h2);
      repeat (200) @(posedge clk_i);
      rd(R_STATUS);
      `CHK({v[8+ENG_AO], v[F_UNDR]}, 2'b10)
      wr(R_START, 32'h20);
      // rise-only mask on line 15: rise flags once, fall not at all
      wr(R_CHG_RISE, 32'h8000);
      dio_i <= 16'h0;
      for (i = 0; i < 2; i++) begin
         repeat (4) @(posedge clk_i);
         dio_i[15] <= !i[0];
         n = 0;
         repeat (8) @(negedge clk_i) if (chg_event_o === 1'b1) n++;
         `CHK(n, 1 - i)
         if (i == 0) rd(R_STATUS);
         if (i == 0) `CHK(v[F_CHG], 1'b1)
         @(posedge clk_i);
      end
      // random counter counts edges on a random line
      c = 4'($random(seed));
      l = 4'($random(seed));
      n = 1 + ($unsigned($random(seed)) % 8);
      wr(8'h14 + c[1:0], 32'h800 | (l << 3));
      repeat (n) begin
         @(posedge clk_i);
         dio_i[l] <= 1'b1;
         repeat (4) @(posedge clk_i);
         dio_i[l] <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
      repeat (4) @(posedge clk_i);
      rd(8'h1C + c[1:0]);
      `CHK(v, 32'(n))
      // same counter as a square wave, routed onto a function line
      wr(8'h18 + c[1:0], 32'h7);
      wr(8'h14 + c[1:0], 32'h803);
      wr(8'h30 + l, {29'h0, 1'b0, c[1:0]});
      wr(R_DIO_FUNC, 32'h1 << l);
      repeat (3) @(negedge clk_i);
      for (i = 0; i < 4; i++) begin
         w0[i] = dio_o[l];
         repeat (8) @(negedge clk_i);
         `CHK(dio_o[l], !w0[i])
      end
      // one digital input sample of a held pattern
      w1 = $random(seed);
      dio_i <= w1[15:0];
      wr(8'h12, TMG);
      wr(R_START, 32'h4);
      repeat (40) @(posedge clk_i);
      wr(R_START, 32'h40);
      rd(R_DI_DATA);
      `CHK(v[15:0], w1[15:0])
      final_report;
   end
endmodule
